// ### include/stats_consts.svh
// Purpose: offsets, widths and figures of the MAC event statistics counters
// Assumes: offsets are byte offsets from the I/O window base
// Notes: definitions only
`ifndef STATS_CONSTS_SVH
`define STATS_CONSTS_SVH

`define STATS_ADDR_W 8
`define STATS_CNT_W 8
`define STATS_NUM_CNT 5

`define STATS_OFF_LATE_COLL 8'h75
`define STATS_OFF_EXCESS_DEFER 8'h7A
`define STATS_OFF_GROUP_TX 8'h7E
`define STATS_OFF_GROUP_RX 8'h7F
`define STATS_OFF_DEFERRED_TX 8'h7B

`define STATS_CNT_RESET 8'h00
`define STATS_CNT_MAX 8'hFF
`define STATS_THRESHOLD 8'hC0

`define STATS_IDX_DEFERRED_TX 3'h0
`define STATS_IDX_EXCESS_DEFER 3'h1
`define STATS_IDX_LATE_COLL 3'h2
`define STATS_IDX_GROUP_RX 3'h3
`define STATS_IDX_GROUP_TX 3'h4

`endif

// ### include/stats_pkg.sv
// Purpose: types shared by the MAC event statistics block
// Assumes: event records arrive from engines on the same clock
// Notes: record fields are valid in the cycle their strobe is high
package stats_pkg;

    typedef logic [7:0] stat_cnt_t;

    // one record per finished transmitted frame
    typedef struct packed {
        logic done;
        logic ok;
        logic deferred;
        logic collided;
        logic excess_defer;
        logic dest_group;
        logic dest_bcast;
    } tx_event_t;

    // one record per finished received frame
    typedef struct packed {
        logic done;
        logic ok;
        logic dest_group;
        logic dest_bcast;
        logic too_long;
        logic fcs_err;
        logic length_err;
        logic align_err;
        logic overrun;
    } rx_event_t;

    typedef struct packed {
        logic rd;
        logic [7:0] addr;
    } io_req_t;

    typedef struct packed {
        logic valid;
        logic hit;
        stat_cnt_t data;
    } io_resp_t;

endpackage

// ### rtl/stat_counter.sv
// Purpose: one 8-bit clear-on-read event counter
// Assumes: inc and clr are single-cycle strobes on clk
// Notes: a clear with a coincident event leaves the counter at one
`timescale 1ns/1ps
`include "stats_consts.svh"

module stat_counter
    import stats_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic inc,
    input wire logic clr,
    output stat_cnt_t count,
    output logic at_threshold
);

    stat_cnt_t cnt_reg;
    stat_cnt_t cnt_next;
    logic thr_reg;
    logic thr_next;

    always_comb begin
        cnt_next = cnt_reg;
        thr_next = 1'b0;
        if (clr && inc) begin
            cnt_next = 8'h01; // RL13
        end else if (clr) begin
            cnt_next = `STATS_CNT_RESET; // RL6
        end else if (inc) begin
            // plain wrap past the top, no saturation
            cnt_next = stat_cnt_t'(cnt_reg + 8'h01); // RL3
        end
        if (inc && cnt_next == `STATS_THRESHOLD) begin
            thr_next = 1'b1; // RL4
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_reg <= `STATS_CNT_RESET; // RL14
            thr_reg <= 1'b0;
        end else if (ce) begin
            cnt_reg <= cnt_next;
            thr_reg <= thr_next;
        end
    end

    assign count = cnt_reg;
    assign at_threshold = thr_reg;

endmodule

// ### rtl/mac_event_stats.sv
// Purpose: five MAC event statistics counters read through I/O space
// Assumes: event records and the enable come from logic on clk
// Notes: reads answer one cycle after the strobe and clear the counter
`timescale 1ns/1ps
`include "stats_consts.svh"

// Function
// RL1: a frame whose first attempt waited on a busy medium bumps deferred_tx_count.
// RL2: a deferred frame that saw any collision is not counted as deferred.
// RL3: every counter wraps from its top value back to zero on the next event.
// RL4: reaching the threshold value raises the stats_threshold_flag.
// RL5: counters move only while stats_count_enable is one and hold otherwise; a host read still clears its counter while the enable is zero.
// RL6: a host read returns the count and clears that counter.
// RL7: a frame whose deferral passed the defer limit bumps excess_defer_count.
// RL8: excess_defer_count moves at most once per frame.
// RL9: each collision later than one slot time bumps late_coll_count.
// RL10: good received group frames count, broadcast ones do not.
// RL11: received frames with length, FCS, alignment or overrun faults do not count.
// RL12: good transmitted group frames count, broadcast ones do not.
// RL13: an event in the same cycle as a clearing read leaves the counter at one.
// RL14: all five counters are zero after reset.
module mac_event_stats
    import stats_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic stats_count_enable,
    input wire tx_event_t tx_event,
    input wire logic late_coll_event,
    input wire rx_event_t rx_event,
    input wire io_req_t io_req,
    output io_resp_t io_resp,
    output logic stats_threshold_flag
);

    // group but not the all-ones broadcast address
    function automatic logic group_only(input logic grp, input logic bcast);
        group_only = grp && !bcast;
    endfunction

    function automatic logic [2:0] addr_to_idx(input logic [7:0] addr,
                                               output logic hit);
        hit = 1'b1;
        case (addr)
            `STATS_OFF_DEFERRED_TX: addr_to_idx = `STATS_IDX_DEFERRED_TX;
            `STATS_OFF_EXCESS_DEFER: addr_to_idx = `STATS_IDX_EXCESS_DEFER;
            `STATS_OFF_LATE_COLL: addr_to_idx = `STATS_IDX_LATE_COLL;
            `STATS_OFF_GROUP_RX: addr_to_idx = `STATS_IDX_GROUP_RX;
            `STATS_OFF_GROUP_TX: addr_to_idx = `STATS_IDX_GROUP_TX;
            default: begin
                addr_to_idx = 3'h0;
                hit = 1'b0;
            end
        endcase
    endfunction

    logic [`STATS_NUM_CNT-1:0] inc_vec;
    logic [`STATS_NUM_CNT-1:0] clr_vec;
    logic [`STATS_NUM_CNT-1:0] thr_vec;
    stat_cnt_t cnt_arr [`STATS_NUM_CNT];

    logic rx_clean;
    logic [2:0] rd_idx;
    logic rd_hit;

    // event qualification
    always_comb begin
        inc_vec = '0;
        rx_clean = !(rx_event.too_long || rx_event.fcs_err ||
                     rx_event.length_err || rx_event.align_err ||
                     rx_event.overrun); // RL11
        if (stats_count_enable) begin // RL5
            // one record per frame, so each frame counts once at most
            inc_vec[`STATS_IDX_DEFERRED_TX] = tx_event.done &&
                tx_event.deferred && !tx_event.collided; // RL1 RL2
            inc_vec[`STATS_IDX_EXCESS_DEFER] = tx_event.done &&
                tx_event.excess_defer; // RL7 RL8
            inc_vec[`STATS_IDX_LATE_COLL] = late_coll_event; // RL9
            inc_vec[`STATS_IDX_GROUP_RX] = rx_event.done && rx_event.ok &&
                rx_clean &&
                group_only(rx_event.dest_group, rx_event.dest_bcast); // RL10
            inc_vec[`STATS_IDX_GROUP_TX] = tx_event.done && tx_event.ok &&
                group_only(tx_event.dest_group, tx_event.dest_bcast); // RL12
        end
    end

    // read decode; the clear lands in the same cycle the value is captured
    always_comb begin
        clr_vec = '0;
        rd_idx = addr_to_idx(io_req.addr, rd_hit);
        if (io_req.rd && rd_hit) begin
            clr_vec[rd_idx] = 1'b1; // RL6
        end
    end

    for (genvar i = 0; i < `STATS_NUM_CNT; i++) begin : g_cnt
        stat_counter u_cnt (
            .clk(clk),
            .srst(srst),
            .ce(ce),
            .inc(inc_vec[i]),
            .clr(clr_vec[i]),
            .count(cnt_arr[i]),
            .at_threshold(thr_vec[i])
        );
    end

    io_resp_t resp_reg;
    io_resp_t resp_next;
    logic flag_reg;
    logic flag_next;

    always_comb begin
        resp_next = '0;
        resp_next.valid = io_req.rd;
        resp_next.hit = io_req.rd && rd_hit;
        if (io_req.rd && rd_hit) begin
            resp_next.data = cnt_arr[rd_idx]; // RL6
        end
        // counter threshold pulses are already one cycle late; one more
        // flop keeps the output straight from a register
        flag_next = |thr_vec; // RL4
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            resp_reg <= '0;
            flag_reg <= 1'b0;
        end else if (ce) begin
            resp_reg <= resp_next;
            flag_reg <= flag_next;
        end
    end

    assign io_resp = resp_reg;
    assign stats_threshold_flag = flag_reg;

endmodule

// ### verif/mac_event_stats_checker.sv
// Purpose: port assertions for the event statistics counters
// Assumes: counts are pinned down by clearing reads around an event
// Notes: flag check is loose since the checker keeps no counts
`timescale 1ns/1ps
`include "stats_consts.svh"
module mac_event_stats_checker
    import stats_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic stats_count_enable,
    input wire tx_event_t tx_event,
    input wire logic late_coll_event,
    input wire rx_event_t rx_event,
    input wire io_req_t io_req,
    input wire io_resp_t io_resp,
    input wire logic stats_threshold_flag
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    wire rd_l = ce && io_req.rd && io_req.addr == `STATS_OFF_LATE_COLL;
    wire rd_x = ce && io_req.rd && io_req.addr == `STATS_OFF_EXCESS_DEFER;
    wire late_on = ce && stats_count_enable && late_coll_event;
    a_read_answers: assert property (ce && io_req.rd |=> io_resp.valid)
        else $error("read not answered");
    a_hit_decode: assert property (ce && io_req.rd |=> io_resp.hit ==
        ($past(io_req.addr) inside {8'h75, 8'h7A, 8'h7B, 8'h7E, 8'h7F}))
        else $error("hit decode wrong");
    a_refused_zero: assert property (io_resp.valid && !io_resp.hit
        |-> io_resp.data == 8'h00) else $error("unmapped data not zero");
    a_read_clears: assert property (rd_l && !late_on ##1 rd_l
        |=> io_resp.data == 8'h00) else $error("read did not clear");
    a_clear_keeps: assert property (rd_l && late_on ##1 rd_l
        |=> io_resp.data == 8'h01) else $error("event lost on clear");
    a_late_counts: assert property (rd_l && !late_on ##1
        late_on && !io_req.rd ##1 rd_l |=> io_resp.data == 8'h01)
        else $error("late collision not counted once");
    a_enable_gates: assert property (rd_l && !late_on ##1
        ce && !stats_count_enable && !io_req.rd ##1 rd_l
        |=> io_resp.data == 8'h00) else $error("counted while disabled");
    a_excess_once: assert property (rd_x && !tx_event.done ##1 ce &&
        stats_count_enable && tx_event.done && tx_event.excess_defer &&
        !io_req.rd ##1 rd_x |=> io_resp.data == 8'h01)
        else $error("excess deferral count wrong");
    a_flag_cause: assert property (stats_threshold_flag
        |-> $past(stats_count_enable, 2)) else $error("flag without count");
endmodule
bind mac_event_stats mac_event_stats_checker u_chk (.clk(clk),
    .srst(srst), .ce(ce), .stats_count_enable(stats_count_enable),
    .tx_event(tx_event), .late_coll_event(late_coll_event),
    .rx_event(rx_event), .io_req(io_req), .io_resp(io_resp),
    .stats_threshold_flag(stats_threshold_flag));

// ### verif/testbench.sv
// Purpose: directed reads and event bursts against the counters
// Assumes: inputs change 1 ns after the rising edge
// Notes: each driving task (ev, rd2, trio) starts with an edge so drives never collide
`timescale 1ns/1ps
`include "stats_consts.svh"
module testbench
    import stats_pkg::*;
;
    logic clk = 0, srst = 1, ce = 1, en = 1, late = 0, flag;
    tx_event_t tx = '0;
    rx_event_t rx = '0;
    io_req_t req = '0;
    io_resp_t resp;
    int mismatches = 0, samples_checked = 0;
    logic [7:0] offs [5] = '{8'h75, 8'h7A, 8'h7B, 8'h7E, 8'h7F};
    always #10 clk = ~clk;
    mac_event_stats dut (.clk(clk), .srst(srst), .ce(ce),
        .stats_count_enable(en), .tx_event(tx), .late_coll_event(late),
        .rx_event(rx), .io_req(req), .io_resp(resp),
        .stats_threshold_flag(flag));
    task give_verdict;
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input string n, input logic [9:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s exp %h seen %h", n, exp, seen);
        end
    endtask
    task ev(input tx_event_t t, input rx_event_t r, input logic l, int n);
        repeat (n) begin
            @(posedge clk);
            #1 tx = t;
            rx = r;
            late = l;
        end
        @(posedge clk);
        #1 tx = '0;
        rx = '0;
        late = 0;
    endtask
    // two back-to-back reads of one offset, l rides with the first
    task rd2(input logic [7:0] a, input logic l, input logic [9:0] e0, e1);
        @(posedge clk);
        #1 req = {1'b1, a};
        late = l;
        @(posedge clk);
        #1 late = 0;
        chk("first read", resp, e0);
        @(posedge clk);
        #1 req.rd = 0;
        chk("second read", resp, e1);
    endtask
    // read, event alone in the gap, read again
    task trio(input logic [7:0] a, input tx_event_t t, input logic l,
        input logic [7:0] e);
        @(posedge clk);
        #1 req = {1'b1, a};
        @(posedge clk);
        #1 req.rd = 0;
        tx = t;
        late = l;
        @(posedge clk);
        #1 req.rd = 1;
        tx = '0;
        late = 0;
        @(posedge clk);
        #1 req.rd = 0;
        chk("trio read", resp, {2'h3, e});
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        give_verdict;
    end
    initial begin
        repeat (10) @(posedge clk);
        #1 srst = 0;
        foreach (offs[i]) rd2(offs[i], 0, 10'h300, 10'h300);
        rd2(8'h70, 0, 10'h200, 10'h200);
        ev('0, '0, 1, 3);
        rd2(8'h75, 0, 10'h303, 10'h300);
        trio(8'h75, '0, 1, 8'h01);
        en = 0;
        trio(8'h75, '0, 1, 8'h00);
        en = 1;
        ev('0, '0, 1, 1);
        rd2(8'h75, 1, 10'h301, 10'h301);
        // frozen by the clock enable, late collisions must not land
        ce = 0;
        ev('0, '0, 1, 4);
        ce = 1;
        rd2(8'h75, 0, 10'h300, 10'h300);
        ev(7'h70, '0, 0, 1);
        ev(7'h78, '0, 0, 1);
        rd2(8'h7B, 0, 10'h301, 10'h300);
        trio(8'h7A, 7'h44, 0, 8'h01);
        ev(7'h62, '0, 0, 1);
        ev(7'h63, '0, 0, 1);
        ev(7'h42, '0, 0, 1);
        rd2(8'h7E, 0, 10'h301, 10'h300);
        ev('0, 9'h1C0, 0, 1);
        ev('0, 9'h1E0, 0, 1);
        for (int i = 0; i < 5; i++) ev('0, 9'h1C0 | (9'h001 << i), 0, 1);
        rd2(8'h7F, 0, 10'h301, 10'h300);
        ev('0, '0, 1, 192);
        chk("flag early", {9'h000, flag}, 10'h000);
        @(posedge clk);
        #1 chk("flag", {9'h000, flag}, 10'h001);
        ev('0, '0, 1, 65);
        rd2(8'h75, 0, 10'h301, 10'h300);
        give_verdict;
    end
endmodule
